// file: hw/tcmc_params.svh
// constants for the timer channel mode control block
// Function
// - capture mode: an active edge on the channel input sets the event flag
// - compare and both PWM modes: a counter match with the channel value sets the flag
// - PWM at 0% or 100% duty never sets the flag, even on a match
// - interrupt request whenever event flag and interrupt enable are both 1
// - flag clears only after a read with flag set, then a write of 0
// - a new event during the clear sequence keeps the flag set
// - reset clears the flag; writing 1 to it does nothing
// - interrupt enable is read/write, gates requests, reads 0 after reset
// - center select clear and upper mode bit set gives edge-aligned PWM
// - with center select and upper bit clear, lower bit picks capture or compare
// - edge/level field 00 releases the channel pin in every mode
// - capture trigger: 01 rising, 10 falling, 11 either edge
// - compare action on match: 00 flag only, 01 toggle, 10 low, 11 high
// - edge-aligned PWM: 10 high-true clears on match, X1 low-true sets on match
// - center-aligned: 10 clears on up-count match, X1 sets on up-count match
// - module-wide center select 1 puts every channel in center-aligned PWM
// - channel value holds capture or compare value; reset clears it
`ifndef TCMC_PARAMS_SVH
`define TCMC_PARAMS_SVH

// ********************
// register map
// ********************
`define TCMC_ADDR_W        2
`define TCMC_OFS_SC        2'h0
`define TCMC_OFS_VAL_HIGH  2'h1
`define TCMC_OFS_VAL_LOW   2'h2

// ********************
// status and control fields
// ********************
`define TCMC_BIT_FLAG      7
`define TCMC_BIT_IRQ_EN    6
`define TCMC_BIT_MODE_UP   5
`define TCMC_BIT_MODE_LO   4
`define TCMC_BIT_ELS_UP    3
`define TCMC_BIT_ELS_LO    2

// ********************
// reset values and encodings
// ********************
`define TCMC_SC_RESET      8'h00
`define TCMC_VAL_RESET     16'h0000
`define TCMC_ELS_RELEASE   2'b00
`define TCMC_ELS_TOGGLE    2'b01
`define TCMC_ELS_LOW       2'b10
`define TCMC_ELS_HIGH      2'b11
`define TCMC_CNT_FREE_MOD  16'hFFFF
`define TCMC_CNT_START     16'h0000

// ********************
// timing: pin must be quiet this many bus clocks before capture mode
// ********************
`define TCMC_PIN_STABLE_CYC 2

`endif

// file: hw/tcmc_pkg.sv
// types shared by the timer channel mode control block
package tcmc_pkg;

  // channel operating mode decoded from the mode bits and center select
  typedef enum logic [1:0] {
    TCMC_MODE_CAPTURE,
    TCMC_MODE_COMPARE,
    TCMC_MODE_EDGE_PWM,
    TCMC_MODE_CENTER_PWM
  } tcmc_mode_e;

  typedef logic [15:0] tcmc_count_t;

endpackage : tcmc_pkg

// file: hw/tcmc_edge_detect.sv
// two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none

module tcmc_edge_detect (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pinAsync,
  output logic      risingPulse,
  output logic      fallingPulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // the first stage feeds only the second; edges are taken after both
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // one-cycle pulses on each synchronised transition
  assign risingPulse  = sync_q & ~last_q;
  assign fallingPulse = ~sync_q & last_q;

endmodule : tcmc_edge_detect

`default_nettype wire

// file: hw/tcmc_channel.sv
// timer channel: mode decode, capture, compare and PWM pin logic, event flag
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "tcmc_params.svh"
`default_nettype none

module tcmc_channel (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic [`TCMC_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWrEn,
  input  wire logic                    regRdEn,
  output logic      [7:0]              regRdData,
  input  wire tcmc_pkg::tcmc_count_t   counterValue,
  input  wire logic                    counterTick,
  input  wire logic                    countingUp,
  input  wire tcmc_pkg::tcmc_count_t   counterModulo,
  input  wire logic                    centerAlignedSelect,
  input  wire logic                    chanPinIn,
  output logic                         chanPinOut,
  output logic                         chanPinOe_n,
  output logic                         chanIrq,
  output tcmc_pkg::tcmc_mode_e         chanMode,
  output tcmc_pkg::tcmc_count_t        chanValue
);
  import tcmc_pkg::*;

  // ********************
  // state
  // ********************
  logic        flag_q;
  logic        flag_d;
  logic        armed_q;
  logic        armed_d;
  logic        irqEn_q;
  logic        modeUp_q;
  logic        modeLo_q;
  logic [1:0]  els_q;
  tcmc_count_t value_q;
  tcmc_count_t value_d;
  logic        pin_q;
  logic        pin_d;
  logic [7:0]  rdData_q;

  // ********************
  // bus decode
  // ********************
  wire selSc   = (regAddr == `TCMC_OFS_SC);
  wire selHigh = (regAddr == `TCMC_OFS_VAL_HIGH);
  wire selLow  = (regAddr == `TCMC_OFS_VAL_LOW);
  wire wrSc    = regWrEn & selSc;
  wire rdSc    = regRdEn & selSc;
  wire wrFlagZero = wrSc & ~regWrData[`TCMC_BIT_FLAG];

  // ********************
  // mode decode
  // ********************
  // center select overrides the channel bits for the whole module
  tcmc_mode_e mode;
  assign mode = centerAlignedSelect ? TCMC_MODE_CENTER_PWM :
                modeUp_q            ? TCMC_MODE_EDGE_PWM :
                modeLo_q            ? TCMC_MODE_COMPARE :
                                      TCMC_MODE_CAPTURE;
  wire isCapture = (mode == TCMC_MODE_CAPTURE);
  wire isCompare = (mode == TCMC_MODE_COMPARE);
  wire isPwm     = (mode == TCMC_MODE_EDGE_PWM) | (mode == TCMC_MODE_CENTER_PWM);
  wire highTrue  = (els_q == `TCMC_ELS_LOW);

  // ********************
  // input edges
  // ********************
  logic pinRise;
  logic pinFall;

  // the synchroniser adds latency, so a pin that moved within the last two
  // clocks can still show an edge right after the switch into capture mode
  tcmc_edge_detect u_edge (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .pinAsync     (chanPinIn),
    .risingPulse  (pinRise),
    .fallingPulse (pinFall)
  );

  // capture trigger from the edge/level field; 00 captures nothing
  wire captureEvent = isCapture &
                      ((els_q[0] & pinRise) | (els_q[1] & pinFall));

  // ********************
  // compare match and duty extremes
  // ********************
  wire         counterAtValue = (counterValue == value_q);
  wire         matchEvent     = counterTick & counterAtValue & ~isCapture;
  wire         periodStart    = counterTick & (counterValue == `TCMC_CNT_START);
  tcmc_count_t effModulo;
  assign effModulo = (counterModulo == `TCMC_CNT_START) ? `TCMC_CNT_FREE_MOD : counterModulo;
  // value 0 gives 0% and a value past the top count gives 100%
  wire dutyExtreme = (value_q == `TCMC_CNT_START) | (value_q > effModulo);

  // one event source per mode; extremes of PWM are silent
  wire flagEvent = captureEvent |
                   (matchEvent & ~(isPwm & dutyExtreme));

  // ********************
  // event flag and clear sequence
  // ********************
  // a fresh event both keeps the flag and restarts the sequence, so a
  // request that lands during the clear is never lost
  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    if (flagEvent) begin
      flag_d  = 1'b1;
      armed_d = 1'b0;
    end else begin
      if (wrFlagZero & armed_q) begin
        flag_d = 1'b0;
      end
      if (rdSc & flag_q) begin
        armed_d = 1'b1;
      end else if (wrSc) begin
        armed_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  // ********************
  // control bits
  // ********************
  wire [7:0] scReset = `TCMC_SC_RESET;

  // polling is the default after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqEn_q  <= scReset[`TCMC_BIT_IRQ_EN];
      modeUp_q <= 1'b0;
      modeLo_q <= 1'b0;
      els_q    <= `TCMC_ELS_RELEASE;
    end else if (wrSc) begin
      irqEn_q  <= regWrData[`TCMC_BIT_IRQ_EN];
      modeUp_q <= regWrData[`TCMC_BIT_MODE_UP];
      modeLo_q <= regWrData[`TCMC_BIT_MODE_LO];
      els_q    <= regWrData[`TCMC_BIT_ELS_UP:`TCMC_BIT_ELS_LO];
    end
  end

  // ********************
  // channel value
  // ********************
  // capture overrides writes; writes are ignored while capturing
  always_comb begin
    value_d = value_q;
    if (captureEvent) begin
      value_d = counterValue;
    end else if (regWrEn & ~isCapture & selHigh) begin
      value_d = {regWrData, value_q[7:0]};
    end else if (regWrEn & ~isCapture & selLow) begin
      value_d = {value_q[15:8], regWrData};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      value_q <= `TCMC_VAL_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  // ********************
  // pin output level
  // ********************
  // a period start and a match in the same tick resolve to the match, so
  // value 0 holds a high-true output low for the whole period
  always_comb begin
    pin_d = pin_q;
    unique case (mode)
      TCMC_MODE_CAPTURE: begin
        pin_d = pin_q;
      end
      TCMC_MODE_COMPARE: begin
        if (matchEvent) begin
          unique case (els_q)
            `TCMC_ELS_RELEASE: pin_d = pin_q;
            `TCMC_ELS_TOGGLE:  pin_d = ~pin_q;
            `TCMC_ELS_LOW:     pin_d = 1'b0;
            `TCMC_ELS_HIGH:    pin_d = 1'b1;
          endcase
        end
      end
      TCMC_MODE_EDGE_PWM: begin
        if (matchEvent) begin
          pin_d = ~highTrue;
        end else if (periodStart) begin
          pin_d = highTrue;
        end
      end
      TCMC_MODE_CENTER_PWM: begin
        if (matchEvent) begin
          pin_d = countingUp ? ~highTrue : highTrue;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // ********************
  // read port
  // ********************
  // data stands only in the cycle after the strobe; unmapped reads give zero
  wire [7:0] scView = {flag_q, irqEn_q, modeUp_q, modeLo_q, els_q, 2'b00};
  wire [7:0] rdMux  = selSc   ? scView :
                      selHigh ? value_q[15:8] :
                      selLow  ? value_q[7:0] : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= regRdEn ? rdMux : 8'h00;
    end
  end

  // ********************
  // outputs
  // ********************
  // capture mode listens to the pin, so it never drives it
  assign chanPinOe_n = (els_q == `TCMC_ELS_RELEASE) | isCapture;
  assign chanPinOut  = pin_q;
  assign chanIrq     = flag_q & irqEn_q;
  assign chanMode    = mode;
  assign chanValue   = value_q;
  assign regRdData   = rdData_q;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_read_while_set;
    rdSc & flag_q & ~flagEvent;
  endsequence

  sequence s_write_zero_quiet;
    wrFlagZero & ~flagEvent & ~regRdEn;
  endsequence

  a_flag_on_capture: assert property (captureEvent |=> flag_q)
    else $error("capture edge did not set the event flag");

  a_flag_on_match: assert property (matchEvent & isCompare |=> flag_q)
    else $error("compare match did not set the event flag");

  a_pwm_extreme_silent: assert property (
    isPwm & dutyExtreme & ~flag_q & ~wrSc & ~regWrEn |=> ~flag_q)
    else $error("event flag set at 0 or 100 percent duty");

  a_irq_follows_flag: assert property ($rose(flag_q) & irqEn_q |-> chanIrq)
    else $error("interrupt missing with flag and enable set");

  a_clear_sequence: assert property (
    s_read_while_set ##1 s_write_zero_quiet |=> ~flag_q)
    else $error("read then write zero did not clear the flag");

  a_clear_needs_read: assert property (
    flag_q & ~armed_q & wrSc & ~flagEvent |=> flag_q)
    else $error("flag cleared without a prior read");

  a_event_keeps_flag: assert property (armed_q & wrFlagZero & flagEvent |=> flag_q)
    else $error("event during clear sequence was lost");

  a_write_one_holds: assert property (
    wrSc & regWrData[`TCMC_BIT_FLAG] & ~flagEvent |=> flag_q == $past(flag_q))
    else $error("writing one changed the event flag");

  a_reset_clears: assert property (disable iff (1'b0) reset |=> ~flag_q & ~irqEn_q & value_q == 16'h0000)
    else $error("reset left flag, enable or value set");

  a_pin_release: assert property (els_q == `TCMC_ELS_RELEASE |-> chanPinOe_n)
    else $error("pin driven with edge/level field zero");

  a_compare_toggle: assert property (
    isCompare & matchEvent & els_q == `TCMC_ELS_TOGGLE |=> chanPinOut != $past(chanPinOut))
    else $error("compare toggle did not invert the pin");

  a_epwm_high_true: assert property (
    mode == TCMC_MODE_EDGE_PWM & highTrue & matchEvent |=> ~chanPinOut)
    else $error("edge PWM high-true match did not clear the pin");

  a_cpwm_up_match: assert property (
    mode == TCMC_MODE_CENTER_PWM & ~highTrue & matchEvent & countingUp |=> chanPinOut)
    else $error("center PWM low-true up match did not set the pin");

  a_capture_value: assert property (captureEvent |=> value_q == $past(counterValue))
    else $error("captured value differs from counter");

endmodule : tcmc_channel

`default_nettype wire

// file: test/tcmc_pin_partner.sv
// far side of the channel pin: an external driver with a pull-up
`timescale 1ns/1ps
`default_nettype none

module tcmc_pin_partner (
  input  wire logic pinOut,
  input  wire logic pinOe_n,
  input  wire logic drvEn,
  input  wire logic drvLevel,
  output logic      pinWire
);
  // ****************
  // wire level
  // ****************
  // the channel wins while it drives; otherwise the driver or the pull-up
  // sets the level, and it moves only on command, so it is quiet before capture
  assign pinWire = !pinOe_n ? pinOut : (drvEn ? drvLevel : 1'b1);
endmodule : tcmc_pin_partner

`default_nettype wire

// file: test/timer_channel_mode_control_tb.sv
// self-checking bench for the timer channel mode control block
`timescale 1ns/1ps
`include "tcmc_params.svh"
`default_nettype none

module timer_channel_mode_control_tb;
  import tcmc_pkg::*;

  // ****************
  // stimulus and observed signals
  // ****************
  logic                    sys_clk       = 1'b0;
  logic                    reset         = 1'b1;
  logic [`TCMC_ADDR_W-1:0] regAddr       = 2'h0;
  logic [7:0]              regWrData     = 8'h00;
  logic                    regWrEn       = 1'b0;
  logic                    regRdEn       = 1'b0;
  logic [7:0]              regRdData;
  tcmc_count_t             counterValue  = 16'h1234;
  logic                    counterTick   = 1'b0;
  logic                    countingUp    = 1'b1;
  tcmc_count_t             counterModulo = 16'h0000;
  logic                    centerSel     = 1'b0;
  logic                    drvLevel      = 1'b0;
  logic                    pinWire;
  logic                    pinOut;
  logic                    pinOe_n;
  logic                    chanIrq;
  tcmc_mode_e              chanMode;
  tcmc_count_t             chanValue;
  logic [7:0]              rdq;
  logic [7:0]              cfg;
  logic [1:0]              e;
  int                      errCount      = 0;
  int                      numChecks     = 0;
  int                      cycles        = 0;

  // clock: 100 ns period
  always #50 sys_clk = ~sys_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      tally_and_finish();
    end
  end

  // ****************
  // instances
  // ****************
  tcmc_channel dut (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrEn             (regWrEn),
    .regRdEn             (regRdEn),
    .regRdData           (regRdData),
    .counterValue        (counterValue),
    .counterTick         (counterTick),
    .countingUp          (countingUp),
    .counterModulo       (counterModulo),
    .centerAlignedSelect (centerSel),
    .chanPinIn           (pinWire),
    .chanPinOut          (pinOut),
    .chanPinOe_n         (pinOe_n),
    .chanIrq             (chanIrq),
    .chanMode            (chanMode),
    .chanValue           (chanValue)
  );

  tcmc_pin_partner partner (
    .pinOut   (pinOut),
    .pinOe_n  (pinOe_n),
    .drvEn    (1'b1),
    .drvLevel (drvLevel),
    .pinWire  (pinWire)
  );

  // ****************
  // bus, counter and pin helpers
  // ****************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    rdq = regRdData;
  endtask : rd

  task automatic tick(input tcmc_count_t v, input logic up = 1'b1);
    @(posedge sys_clk);
    counterValue <= v;
    countingUp   <= up;
    counterTick  <= 1'b1;
    @(posedge sys_clk);
    counterTick  <= 1'b0;
    #1;
  endtask : tick

  // the pin goes through two sync flops before the flag flop takes the edge
  task automatic setPin(input logic lvl);
    @(posedge sys_clk);
    drvLevel <= lvl;
    repeat (4) @(posedge sys_clk);
  endtask : setPin

  task automatic clr(input logic [7:0] c);
    rd(2'h0);
    wr(2'h0, c);
  endtask : clr

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    #1;
    chk("irq", 16'h0000, 16'(chanIrq));
    chk("oe_n", 16'h0001, 16'(pinOe_n));
    rd(2'h0);
    chk("status", 16'h0000, 16'(rdq));
    rd(2'h3);
    chk("unmapped", 16'h0000, 16'(rdq));
    wr(2'h1, 8'hAA);
    chk("value ignored", 16'h0000, chanValue);
    chk("mode", 16'(TCMC_MODE_CAPTURE), 16'(chanMode));
  endtask : t_reset

  task automatic t_capture();
    for (int i = 1; i < 4; i++) begin
      e   = 2'(i);
      cfg = {4'h0, e, 2'b00};
      wr(2'h0, cfg);                                     // pin quiet beforehand
      chk("oe_n capture", 16'h0001, 16'(pinOe_n));
      setPin(1'b1);
      rd(2'h0);
      chk("rise", 16'({e[0], cfg[6:0]}), 16'(rdq));
      if (e == 2'h1) chk("captured", 16'h1234, chanValue);
      wr(2'h0, cfg);
      setPin(1'b0);
      rd(2'h0);
      chk("fall", 16'({e[1], cfg[6:0]}), 16'(rdq));
      wr(2'h0, cfg);
    end
  endtask : t_capture

  // order 10, 01, 11, 00 so that the toggle starts from a known low
  task automatic t_compare();
    wr(2'h0, 8'h10);                                     // leave capture, value writes are refused there
    wr(2'h2, 8'h50);
    wr(2'h1, 8'h00);
    chk("value", 16'h0050, chanValue);
    for (int i = 3; i >= 0; i--) begin
      e   = 2'(8'h9C >> (2 * i));
      cfg = {4'h5, e, 2'b00};
      wr(2'h0, cfg);
      chk("mode", 16'(TCMC_MODE_COMPARE), 16'(chanMode));
      tick(16'h0051);
      chk("no match", 16'h0000, 16'(chanIrq));
      tick(16'h0050);
      chk("match irq", 16'h0001, 16'(chanIrq));
      chk("oe_n", 16'(e == 2'h0), 16'(pinOe_n));
      if (e != 2'h0) chk("pin", 16'(e != 2'h2), 16'(pinOut));
      clr(cfg);
    end
  endtask : t_compare

  task automatic t_clear();
    cfg = 8'h50;
    wr(2'h0, cfg);
    tick(16'h0050);
    wr(2'h0, cfg | 8'h80);
    chk("write one", 16'h0001, 16'(chanIrq));
    wr(2'h0, cfg);
    chk("no read", 16'h0001, 16'(chanIrq));
    rd(2'h0);
    tick(16'h0050);
    wr(2'h0, cfg);
    chk("new event", 16'h0001, 16'(chanIrq));
    clr(cfg);
    chk("cleared", 16'h0000, 16'(chanIrq));
    wr(2'h0, 8'h10);
    tick(16'h0050);
    chk("masked", 16'h0000, 16'(chanIrq));
    rd(2'h0);
    chk("polled", 16'h0090, 16'(rdq));
    wr(2'h0, 8'h10);
  endtask : t_clear

  task automatic t_edge_pwm();
    for (int i = 0; i < 2; i++) begin
      cfg = (i == 0) ? 8'h28 : 8'h24;
      wr(2'h0, cfg);
      chk("mode", 16'(TCMC_MODE_EDGE_PWM), 16'(chanMode));
      tick(16'h0000);
      chk("start", 16'(i == 0), 16'(pinOut));
      tick(16'h0050);
      chk("match", 16'(i != 0), 16'(pinOut));
      rd(2'h0);
      chk("flag", 16'({1'b1, cfg[6:0]}), 16'(rdq));
      wr(2'h0, cfg);
    end
    wr(2'h2, 8'h00);
    tick(16'h0000);
    rd(2'h0);
    chk("zero duty", 16'(cfg), 16'(rdq));
    // a value past the top count is full duty and stays silent too
    @(posedge sys_clk);
    counterModulo <= 16'h0040;
    wr(2'h2, 8'h50);
    tick(16'h0050);
    rd(2'h0);
    chk("full duty", 16'(cfg), 16'(rdq));
    @(posedge sys_clk);
    counterModulo <= 16'h0000;
  endtask : t_edge_pwm

  task automatic t_center();
    wr(2'h2, 8'h50);
    @(posedge sys_clk);
    centerSel <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cfg = (i == 0) ? 8'h28 : 8'h04;
      wr(2'h0, cfg);
      chk("mode", 16'(TCMC_MODE_CENTER_PWM), 16'(chanMode));
      tick(16'h0050, 1'b1);
      chk("up match", 16'(i), 16'(pinOut));
      tick(16'h0050, 1'b0);
      chk("down match", 16'(i == 0), 16'(pinOut));
      clr(cfg);
    end
  endtask : t_center

  // ****************
  // verdict and main sequence
  // ****************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // reset for three edges, then each scenario in turn
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_capture();
    t_compare();
    t_clear();
    t_edge_pwm();
    t_center();
    tally_and_finish();
  end
endmodule : timer_channel_mode_control_tb

`default_nettype wire
